// ### rtl/hph_pkg.sv
// Package of constants and types for the host power handshake block
// Function
// - While the host wake request is asserted the device wakes or stays awake, otherwise it may sleep once idle.
// - The device asserts its host wake output while it needs host attention and releases it afterwards.
// - Software selects high-true or low-true levels for the incoming and outgoing wake lines.
// - The reference clock request is high while the reference clock is needed and low in sleep.
// - The pad function selection of the handshake pins holds zero.
// - After reset and initialisation the device drives its request-to-send output low to show it is ready.
// - The RF sections are gated on and off within each transmit and receive packet.
// - In sniff, hold and park the device runs on the low-power oscillator and wakes after a set period.
// - In low-power shutdown all outputs are tri-stated and most inputs are disabled.
// - Leaving shutdown is a normal power-up and keeps no earlier state; the period, mask and pending interrupt registers are kept.
// - The FM subsystem is either fully on or fully off.
// - With low-power scan on, detected activation energy reverts the device to conventional scanning.
package hph_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] HPH_CTRL_OFS = 8'h00;
  localparam logic [7:0] HPH_STAT_OFS = 8'h04;
  localparam logic [7:0] HPH_IRQ_OFS = 8'h08;
  localparam logic [7:0] HPH_MASK_OFS = 8'h0C;
  localparam logic [7:0] HPH_PERIOD_OFS = 8'h10;
  localparam logic [7:0] HPH_PADSEL_OFS = 8'h14;

  // ------------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------------
  localparam int HPH_C_WAKE_POL = 0;
  localparam int HPH_C_HOST_POL = 1;
  localparam int HPH_C_INIT_DONE = 2;
  localparam int HPH_C_HOST_ATTN = 3;
  localparam int HPH_C_SLEEP_OK = 4;
  localparam int HPH_C_LP_MODE = 5;
  localparam int HPH_C_SHUTDOWN = 6;
  localparam int HPH_C_FM_ON = 7;
  localparam int HPH_C_LPSCAN = 8;

  // Interrupt bit positions
  localparam int HPH_I_WAKE = 0;
  localparam int HPH_I_SLEEP = 1;
  localparam int HPH_I_TIMER = 2;
  localparam int HPH_I_SCAN = 3;
  localparam int HPH_IRQ_W = 4;

  // Reset values and bus responses
  localparam logic [31:0] HPH_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HPH_PERIOD_RST = 32'h0000_0064;
  localparam logic [31:0] HPH_SLVERR = 32'h0000_0000;
  localparam logic [1:0] HPH_RESP_OK = 2'b00;
  localparam logic [1:0] HPH_RESP_ERR = 2'b10;

  // Timing: RF gating guard after a packet, in ns
  localparam int HPH_RF_GUARD_NS = 50;
  localparam int HPH_CLK_NS = 10;
  localparam int HPH_RF_GUARD_CYC =
    (HPH_RF_GUARD_NS + HPH_CLK_NS - 1) / HPH_CLK_NS;

  // Power states, one-hot
  typedef enum logic [4:0] {
    HPH_OFF = 5'b00001,
    HPH_INIT = 5'b00010,
    HPH_ACTIVE = 5'b00100,
    HPH_SLEEP = 5'b01000,
    HPH_LOWPWR = 5'b10000
  } hph_state_type;

  // Handshake pin group towards the host
  typedef struct packed {
    logic host_wake;
    logic host_wake_oe;
    logic ref_clock_request;
    logic ref_clock_request_oe;
    logic serial_request_to_send_n;
    logic rts_oe;
  } hph_pins_type;

endpackage

// ### rtl/hph_top.sv
// Host power handshake controller with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hph_top
  import hph_pkg::*;
#(
  parameter int TIMER_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host pins
  input wire logic device_wake_request,
  output hph_pins_type pins,
  // Baseband side
  input wire logic packet_active,
  input wire logic scan_energy,
  output logic rf_enable,
  output logic lpo_select,
  output logic fm_power,
  output logic conventional_scan,
  output logic inputs_enable,
  output logic irq
);

  // ------------------------------------------------------------------
  // State record
  // ------------------------------------------------------------------
  typedef struct packed {
    hph_state_type st;
    logic [2:0] sync;
    logic wake;
    logic [31:0] ctrl;
    logic [31:0] period;
    logic [HPH_IRQ_W-1:0] stat;
    logic [HPH_IRQ_W-1:0] mask;
    logic [TIMER_W-1:0] timer;
    logic [3:0] guard;
    logic lpscan_fallback;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hph_regs_type;

  hph_regs_type r_reg, r_next;

  // Maps an address to a known register
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == HPH_CTRL_OFS) || (a == HPH_STAT_OFS) ||
              (a == HPH_IRQ_OFS) || (a == HPH_MASK_OFS) ||
              (a == HPH_PERIOD_OFS) || (a == HPH_PADSEL_OFS);
  endfunction

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  logic wake_req;
  logic do_write;
  logic do_read;
  logic [HPH_IRQ_W-1:0] events;
  logic [31:0] wv;
  logic [31:0] stat_word;

  // Handshake readiness is combinational
  assign s_axi_awready = !r_reg.aw_hold && !r_reg.bvalid;
  assign s_axi_wready = !r_reg.w_hold && !r_reg.bvalid;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;

  // Synchronised request decoded with its programmed level
  assign wake_req = r_reg.wake ^ r_reg.ctrl[HPH_C_WAKE_POL];

  // Status word: live state in low bits
  assign stat_word = {24'h00_0000, 3'b000, r_reg.st};

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    events = '0;
    wv = 32'h0000_0000;
    // Three-stage synchroniser; change counts when stages 2 and 3 agree
    r_next.sync = {r_reg.sync[1:0], device_wake_request};
    if (r_reg.sync[2] == r_reg.sync[1]) begin
      r_next.wake = r_reg.sync[2];
    end

    // Write channel capture, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_hold = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_hold = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    do_write = r_reg.aw_hold && r_reg.w_hold;
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    // Power state machine
    unique case (r_reg.st)
      HPH_OFF: begin
        r_next.st = HPH_INIT;
      end
      HPH_INIT: begin
        if (r_reg.ctrl[HPH_C_INIT_DONE]) begin
          r_next.st = HPH_ACTIVE;
        end
      end
      HPH_ACTIVE: begin
        // Sleep only with request released and firmware idle
        if (!wake_req && r_reg.ctrl[HPH_C_SLEEP_OK]) begin
          r_next.st = r_reg.ctrl[HPH_C_LP_MODE] ? HPH_LOWPWR : HPH_SLEEP;
          r_next.timer = r_reg.period[TIMER_W-1:0];
          events[HPH_I_SLEEP] = 1'b1;
        end
      end
      HPH_SLEEP: begin
        if (wake_req) begin
          r_next.st = HPH_ACTIVE;
          events[HPH_I_WAKE] = 1'b1;
        end
      end
      HPH_LOWPWR: begin
        // Timed wake on the low-power oscillator period
        if (wake_req) begin
          r_next.st = HPH_ACTIVE;
          events[HPH_I_WAKE] = 1'b1;
        end else if (r_reg.timer == '0) begin
          r_next.st = HPH_ACTIVE;
          events[HPH_I_TIMER] = 1'b1;
        end else begin
          r_next.timer = r_reg.timer - 1'b1;
        end
      end
    endcase

    // RF guard stretches enable a few cycles after a packet ends
    if (packet_active && r_reg.st == HPH_ACTIVE) begin
      r_next.guard = 4'(HPH_RF_GUARD_CYC);
    end else if (r_reg.guard != 4'h0) begin
      r_next.guard = r_reg.guard - 4'h1;
    end

    // Scan fallback is sticky while the mode is on
    if (!r_reg.ctrl[HPH_C_LPSCAN]) begin
      r_next.lpscan_fallback = 1'b0;
    end else if (scan_energy) begin
      r_next.lpscan_fallback = 1'b1;
      if (!r_reg.lpscan_fallback) begin
        events[HPH_I_SCAN] = 1'b1;
      end
    end

    // Register writes
    if (do_write) begin
      r_next.aw_hold = 1'b0;
      r_next.w_hold = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = addr_ok(r_reg.aw_addr) ? HPH_RESP_OK : HPH_RESP_ERR;
      unique case (r_reg.aw_addr)
        HPH_CTRL_OFS: begin
          r_next.ctrl = merge(r_reg.ctrl, r_reg.w_data, r_reg.w_strb);
        end
        HPH_IRQ_OFS: begin
          wv = merge(32'h0000_0000, r_reg.w_data, r_reg.w_strb);
        end
        HPH_MASK_OFS: begin
          r_next.mask = r_reg.w_data[HPH_IRQ_W-1:0];
        end
        HPH_PERIOD_OFS: begin
          r_next.period = merge(r_reg.period, r_reg.w_data, r_reg.w_strb);
        end
        default: begin
        end
      endcase
    end
    // Write one to clear; a new event wins over the clear
    r_next.stat = (r_reg.stat & ~wv[HPH_IRQ_W-1:0]) | events;

    // Shutdown restarts like power-up; period, mask and pending events are kept
    if (r_reg.ctrl[HPH_C_SHUTDOWN]) begin
      r_next.st = HPH_OFF;
      r_next.ctrl = HPH_CTRL_RST;
      r_next.ctrl[HPH_C_SHUTDOWN] = 1'b1;
      r_next.timer = '0;
      r_next.lpscan_fallback = 1'b0;
      r_next.guard = 4'h0;
      if (do_write && r_reg.aw_addr == HPH_CTRL_OFS) begin
        r_next.ctrl = merge(r_reg.ctrl, r_reg.w_data, r_reg.w_strb);
      end
    end

    // Read channel
    do_read = s_axi_arvalid && s_axi_arready;
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (do_read) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = addr_ok(s_axi_araddr) ? HPH_RESP_OK : HPH_RESP_ERR;
      unique case (s_axi_araddr)
        HPH_CTRL_OFS: r_next.rdata = r_reg.ctrl;
        HPH_STAT_OFS: r_next.rdata = stat_word;
        HPH_IRQ_OFS: r_next.rdata = {28'h000_0000, r_reg.stat};
        HPH_MASK_OFS: r_next.rdata = {28'h000_0000, r_reg.mask};
        HPH_PERIOD_OFS: r_next.rdata = r_reg.period;
        HPH_PADSEL_OFS: r_next.rdata = 32'h0000_0000;
        default: r_next.rdata = HPH_SLVERR;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.st <= HPH_OFF;
      r_reg.ctrl <= HPH_CTRL_RST;
      r_reg.period <= HPH_PERIOD_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  logic awake;
  logic down;
  assign awake = (r_reg.st == HPH_ACTIVE) || (r_reg.st == HPH_INIT);
  assign down = r_reg.ctrl[HPH_C_SHUTDOWN];

  // Pins: all tri-stated in shutdown to avoid loading the host
  always_comb begin
    pins.host_wake = r_reg.ctrl[HPH_C_HOST_ATTN] ^
                     r_reg.ctrl[HPH_C_HOST_POL];
    pins.host_wake_oe = !down;
    pins.ref_clock_request = awake;
    pins.ref_clock_request_oe = !down;
    pins.serial_request_to_send_n = (r_reg.st != HPH_ACTIVE) &&
                                    (r_reg.st != HPH_SLEEP) &&
                                    (r_reg.st != HPH_LOWPWR);
    pins.rts_oe = !down;
  end

  assign rf_enable = (r_reg.st == HPH_ACTIVE) &&
                     (packet_active || r_reg.guard != 4'h0);
  assign lpo_select = (r_reg.st == HPH_LOWPWR) ||
                      (r_reg.st == HPH_SLEEP);
  assign fm_power = r_reg.ctrl[HPH_C_FM_ON] && !down;
  assign conventional_scan = !r_reg.ctrl[HPH_C_LPSCAN] ||
                             r_reg.lpscan_fallback;
  assign inputs_enable = !down;
  assign irq = |(r_reg.stat & r_reg.mask);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_sleep_needs_release: assert property (@(posedge clk) disable iff (!nrst)
    (r_reg.st == HPH_ACTIVE && wake_req && !down) |=>
      r_reg.st == HPH_ACTIVE)
    else $error("left active while wake request held");
  a_wake_from_sleep: assert property (@(posedge clk) disable iff (!nrst)
    (r_reg.st == HPH_SLEEP && wake_req && !down) |=>
      r_reg.st == HPH_ACTIVE)
    else $error("did not wake on request");
  a_refclk_sleep: assert property (@(posedge clk) disable iff (!nrst)
    (r_reg.st == HPH_SLEEP) |-> !pins.ref_clock_request)
    else $error("clock requested in sleep");
  a_rts_ready: assert property (@(posedge clk) disable iff (!nrst)
    (r_reg.st == HPH_INIT && r_reg.ctrl[HPH_C_INIT_DONE] && !down)
      |=> !pins.serial_request_to_send_n)
    else $error("rts not low after init");
  a_rf_gated: assert property (@(posedge clk) disable iff (!nrst)
    $fell(packet_active) && r_reg.st == HPH_ACTIVE && !down
      |-> ##[1:6] !rf_enable || r_reg.st != HPH_ACTIVE
      || packet_active)
    else $error("rf stays on after packet");
  a_timed_wake: assert property (@(posedge clk) disable iff (!nrst)
    (r_reg.st == HPH_LOWPWR && r_reg.timer == '0 && !down)
      |=> r_reg.st == HPH_ACTIVE)
    else $error("no timed wake");
  a_shutdown_tri: assert property (@(posedge clk) disable iff (!nrst)
    down |-> !pins.host_wake_oe && !pins.rts_oe &&
      !pins.ref_clock_request_oe && !inputs_enable)
    else $error("outputs driven in shutdown");
  a_shutdown_fresh: assert property (@(posedge clk) disable iff (!nrst)
    down |=> r_reg.st == HPH_OFF && r_reg.timer == '0)
    else $error("state kept across shutdown");
  a_scan_revert: assert property (@(posedge clk) disable iff (!nrst)
    (r_reg.ctrl[HPH_C_LPSCAN] && scan_energy && !down)
      |=> conventional_scan)
    else $error("no revert to conventional scan");
  a_sync_delay: assert property (@(posedge clk) disable iff (!nrst)
    $changed(r_reg.wake) |-> $past(r_reg.sync[2]) == r_reg.wake)
    else $error("wake changed without synchroniser");

  c_sleep_entry: cover property (@(posedge clk) disable iff (!nrst)
    r_reg.st == HPH_ACTIVE ##1 r_reg.st == HPH_SLEEP);
  c_timer_wake: cover property (@(posedge clk) disable iff (!nrst)
    r_reg.st == HPH_LOWPWR ##1 r_reg.st == HPH_ACTIVE);
  c_scan_fallback: cover property (@(posedge clk) disable iff (!nrst)
    $rose(r_reg.lpscan_fallback));

endmodule
`default_nettype wire

// ### verification/hph_host_model.sv
// Host processor model for the wake handshake lines
`timescale 1ns/1ps
`default_nettype none
module hph_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Commands from the bench
  input wire logic want_wake,
  input wire logic configured,
  input wire logic wake_inv,
  input wire logic host_inv,
  // Device pins
  input wire logic host_wake,
  input wire logic host_wake_oe,
  output logic device_wake_request,
  output logic host_awake
);
  // ----------------------------------------------------------------
  // Wake lines
  // ----------------------------------------------------------------
  logic last_reg;
  logic line;
  // Held asserted until configuration ends, whatever is wanted
  assign device_wake_request = (want_wake | ~configured) ^ wake_inv;
  // A released line floats, so show the opposite of its last level
  assign line = host_wake_oe ? host_wake : ~last_reg;
  // Last driven level of the attention line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_reg <= 1'b0;
    end else if (host_wake_oe) begin
      last_reg <= host_wake;
    end
  end
  // Host stays awake while the device asks for attention
  assign host_awake = line ^ host_inv;
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench for the host power handshake block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hph_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] INI = 32'h0000_0001 << HPH_C_INIT_DONE;
  localparam logic [31:0] SOK = 32'h0000_0001 << HPH_C_SLEEP_OK;
  localparam logic [31:0] WPL = 32'h0000_0001 << HPH_C_WAKE_POL;
  localparam logic [31:0] HPL = 32'h0000_0001 << HPH_C_HOST_POL;
  localparam logic [31:0] ATT = 32'h0000_0001 << HPH_C_HOST_ATTN;
  localparam logic [31:0] LPM = 32'h0000_0001 << HPH_C_LP_MODE;
  localparam logic [31:0] SHD = 32'h0000_0001 << HPH_C_SHUTDOWN;
  localparam logic [31:0] FMO = 32'h0000_0001 << HPH_C_FM_ON;
  localparam logic [31:0] LPS = 32'h0000_0001 << HPH_C_LPSCAN;
  logic clk = 1'b0, nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdat;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic packet_active = 1'b0, scan_energy = 1'b0;
  logic want_wake = 1'b1, configured = 1'b0;
  logic wake_inv = 1'b0, host_inv = 1'b0;
  logic dwr, host_awake, rf_enable, lpo_select, fm_power;
  logic conventional_scan, inputs_enable, irq;
  hph_pins_type pins;
  int error_cnt = 0, checks_done = 0, cyc = 0, n;

  // Free-running clock
  always #5 clk = ~clk;

  hph_top u_dut (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .device_wake_request(dwr), .pins(pins),
    .packet_active(packet_active), .scan_energy(scan_energy),
    .rf_enable(rf_enable), .lpo_select(lpo_select),
    .fm_power(fm_power), .conventional_scan(conventional_scan),
    .inputs_enable(inputs_enable), .irq(irq)
  );

  hph_host_model u_host (
    .clk(clk), .nrst(nrst), .want_wake(want_wake),
    .configured(configured), .wake_inv(wake_inv), .host_inv(host_inv),
    .host_wake(pins.host_wake), .host_wake_oe(pins.host_wake_oe),
    .device_wake_request(dwr), .host_awake(host_awake)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rdat = rdata;
        resp = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask

  // State changes take a few cycles, so read until it settles
  task automatic poll(input string nm, input logic [7:0] a,
                      input logic [31:0] m, e);
    int k = 0;
    rd(a);
    while ((rdat & m) !== e && k < 60) begin
      rd(a);
      k++;
    end
    chk(nm, rdat & m, e);
  endtask

  // Let the edge's updates land before sampling
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Hang guard: the whole sequence needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    chk("rts_n in reset", pins.serial_request_to_send_n, 1);
    nrst <= 1'b1;
    rd(HPH_CTRL_OFS);
    chk("ctrl reset", rdat, HPH_CTRL_RST);
    rd(HPH_PERIOD_OFS);
    chk("period reset", rdat, HPH_PERIOD_RST);
    wr(HPH_PADSEL_OFS, 32'h0000_0001);
    rd(HPH_PADSEL_OFS);
    chk("pad select", rdat, 32'h0000_0000);
    rd(8'h18);
    chk("unmapped read", {30'h0, resp}, {30'h0, HPH_RESP_ERR});
    wr(8'h1C, 32'h0000_0001);
    chk("unmapped write", {30'h0, resp}, {30'h0, HPH_RESP_ERR});
    poll("init state", HPH_STAT_OFS, 32'h1F, 32'(HPH_INIT));
    chk("not ready yet", pins.serial_request_to_send_n, 1);
    wr(HPH_CTRL_OFS, INI);
    poll("active state", HPH_STAT_OFS, 32'h1F, 32'(HPH_ACTIVE));
    chk("ready", pins.serial_request_to_send_n, 0);
    chk("clock wanted", pins.ref_clock_request, 1);
    configured <= 1'b1;
    wr(HPH_MASK_OFS, 32'h0000_000F);
    // RF follows the packet, with a short trailing guard
    chk("rf idle", rf_enable, 0);
    @(posedge clk);
    packet_active <= 1'b1;
    tick(2);
    chk("rf in packet", rf_enable, 1);
    @(posedge clk);
    packet_active <= 1'b0;
    tick(2);
    chk("rf guard", rf_enable, 1);
    tick(HPH_RF_GUARD_CYC + 3);
    chk("rf off", rf_enable, 0);
    // Sleep and wake, with both wake polarities
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      wake_inv <= p[0];
      want_wake <= 1'b0;
      wr(HPH_CTRL_OFS, INI | SOK | (p[0] ? WPL : 32'h0));
      poll("sleep", HPH_STAT_OFS, 32'h1F, 32'(HPH_SLEEP));
      chk("clock released", pins.ref_clock_request, 0);
      @(posedge clk);
      want_wake <= 1'b1;
      tick(2);
      chk("wake synchroniser", lpo_select, 1);
      poll("woken", HPH_STAT_OFS, 32'h1F, 32'(HPH_ACTIVE));
      rd(HPH_IRQ_OFS);
      chk("wake events", rdat & 32'h3, 32'h3);
      chk("irq raised", irq, 1);
      wr(HPH_IRQ_OFS, 32'h0000_000F);
      tick(1);
      chk("irq cleared", irq, 0);
    end
    wr(HPH_CTRL_OFS, INI);
    @(posedge clk);
    wake_inv <= 1'b0;
    // Attention line towards the host, both polarities
    wr(HPH_CTRL_OFS, INI | ATT);
    tick(1);
    chk("host woken", host_awake, 1);
    @(posedge clk);
    host_inv <= 1'b1;
    wr(HPH_CTRL_OFS, INI | ATT | HPL);
    tick(1);
    chk("host woken low", host_awake, 1);
    chk("attention level", pins.host_wake, 0);
    @(posedge clk);
    host_inv <= 1'b0;
    wr(HPH_CTRL_OFS, INI);
    tick(1);
    chk("host may sleep", host_awake, 0);
    // Timed low-power connection mode
    wr(HPH_PERIOD_OFS, 32'h0000_0014);
    @(posedge clk);
    want_wake <= 1'b0;
    // Sleep entry needs the idle flag as well as the released request
    wr(HPH_CTRL_OFS, INI | SOK | LPM);
    n = 0;
    while (!lpo_select && n < 100) begin
      tick(1);
      n++;
    end
    chk("low-power clock", lpo_select, 1);
    n = 0;
    while (lpo_select && n < 200) begin
      tick(1);
      n++;
    end
    chk("timed wake", 32'(n >= 10 && n <= 40), 1);
    @(posedge clk);
    want_wake <= 1'b1;
    wr(HPH_CTRL_OFS, INI);
    poll("back active", HPH_STAT_OFS, 32'h1F, 32'(HPH_ACTIVE));
    rd(HPH_IRQ_OFS);
    chk("timer event", rdat & 32'h4, 32'h4);
    wr(HPH_IRQ_OFS, 32'h0000_000F);
    // FM power and scan fallback, with masking
    wr(HPH_CTRL_OFS, INI | FMO | LPS);
    tick(1);
    chk("fm on", fm_power, 1);
    chk("low-power scan", conventional_scan, 0);
    @(posedge clk);
    scan_energy <= 1'b1;
    @(posedge clk);
    scan_energy <= 1'b0;
    tick(3);
    chk("scan fallback", conventional_scan, 1);
    wr(HPH_MASK_OFS, 32'h0000_0000);
    tick(1);
    chk("irq masked", irq, 0);
    rd(HPH_IRQ_OFS);
    chk("scan event", rdat & 32'h8, 32'h8);
    wr(HPH_MASK_OFS, 32'h0000_000F);
    tick(1);
    chk("irq unmasked", irq, 1);
    wr(HPH_IRQ_OFS, 32'h0000_000F);
    // Shutdown releases the pins and forgets the control settings
    wr(HPH_CTRL_OFS, INI | FMO | SHD);
    tick(2);
    chk("wake pins off", {pins.host_wake_oe, pins.rts_oe}, 0);
    chk("clock pin off", pins.ref_clock_request_oe, 0);
    chk("inputs off", inputs_enable, 0);
    chk("fm off", fm_power, 0);
    poll("off state", HPH_STAT_OFS, 32'h1F, 32'(HPH_OFF));
    // Only the shutdown bit survives; init and FM settings are dropped
    rd(HPH_CTRL_OFS);
    chk("ctrl dropped", rdat, SHD);
    wr(HPH_CTRL_OFS, 32'h0000_0000);
    rd(HPH_CTRL_OFS);
    chk("ctrl forgotten", rdat, 32'h0000_0000);
    poll("restart", HPH_STAT_OFS, 32'h1F, 32'(HPH_INIT));
    chk("rts after restart", pins.serial_request_to_send_n, 1);
    test_done();
  end
endmodule
`default_nettype wire
